// *** dv/pwm_load_model.sv ***
/*
 * Load on one PWM pin: measures high time and period in clocks.
 * Assumes a pin that is a clean registered level on the bench clock.
 */
`timescale 1ns/1ns
module pwm_load_model
(
   input  wire logic clk,
   input  wire logic pin,
   output int        high_len,   // High clocks of the last whole period
   output int        period_len, // Clocks between the last two rises
   output int        rises       // Rising edges seen so far
);
   int   run_len;  // Clocks since the last rise
   int   hi_acc;   // High clocks since the last rise
   logic last;     // Pin one clock ago

   // ---------------------------------------------------------------
   // Edge timing, reported at each rise; the first rise reports the clocks since time zero
   // ---------------------------------------------------------------
   initial
   begin
      run_len    = 0;
      hi_acc     = 0;
      last       = 1'b0;
      high_len   = 0;
      period_len = 0;
      rises      = 0;
   end

   always @(posedge clk)
   begin
      if (pin === 1'b1 && last !== 1'b1)
      begin
         period_len <= run_len;
         high_len   <= hi_acc;
         run_len    <= 1;
         hi_acc     <= 1;
         rises      <= rises + 1;
      end
      else
      begin
         run_len <= run_len + 1;
         hi_acc  <= hi_acc + ((pin === 1'b1) ? 1 : 0);
      end
      last <= pin;
   end
endmodule

// *** dv/timer_based_pwm_unit_bench.sv ***
/*
 * Bench for the PWM unit: APB master, reference figures, pin loads.
 * Assumes the package offsets and a zero wait state APB slave.
 */
`timescale 1ns/1ns
module timer_based_pwm_unit_bench;
   import pwm_unit_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  pin;
   logic [31:0] rd;
   logic        err;
   int          hl[2];               // High time per load
   int          pl[2];               // Period per load
   int          rs[2];               // Rises per load
   int          duty[2];             // Model duty per unit
   int          ps_q[$] = '{1, 4, 16}; // Prescale factor per code
   int          failures;
   int          cmp_count;
   int          r0;

   initial clk = 1'b0;
   always #4 clk = ~clk;

   timer_based_pwm_unit u_timer_based_pwm_unit
   (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .UNIT1_PIN(pin[0]), .UNIT2_PIN(pin[1])
   );

   for (genvar g = 0; g < 2; g++)
   begin : g_load
      pwm_load_model u_pwm_load_model
      (
         .clk(clk), .pin(pin[g]), .high_len(hl[g]), .period_len(pl[g]),
         .rises(rs[g])
      );
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high.
   // It opens one edge after the last release, so no signal is set twice.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // The watchdog alone ends a wait that never sees pready
      while (pready !== 1'b1)
         @(posedge clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Duty low register, then control with duty low bits and mode
   task automatic cfg(input int u, input logic [9:0] d, input logic m);
      duty[u] = d;
      apb(1'b1, OFS_U1_DUTY_LOW + 8'(12 * u), d[9:2]);
      apb(1'b1, OFS_U1_CTRL + 8'(12 * u), {2'b0, d[1:0], m ? 4'hc : 4'h0});
   endtask

   task automatic final_report();
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard, far past the few thousand clocks the tests need
   initial
   begin
      #(8 * 20000);
      failures++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      failures  = 0;
      cmp_count = 0;
      void'($urandom(35455));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, OFS_PERIOD, 8'h0);
      cmp(rd, {24'h0, PERIOD_RST});
      apb(1'b0, OFS_TIMER_CTRL, 8'h0);
      cmp(rd, {24'h0, TIMER_CTRL_RST});
      apb(1'b0, OFS_U1_CTRL, 8'h0);
      cmp(rd, {24'h0, UNIT_CTRL_RST});
      apb(1'b0, 8'h24, 8'h0);
      cmp({rd[30:0], err}, 32'h1);
      apb(1'b0, OFS_TIMER_COUNT, 8'h0);
      cmp(rd, {24'h0, TIMER_COUNT_RST});
      // A stopped timer keeps a written count
      apb(1'b1, OFS_TIMER_COUNT, 8'h5a);
      apb(1'b0, OFS_TIMER_COUNT, 8'h0);
      cmp(rd, 32'h5a);
      apb(1'b1, OFS_TIMER_COUNT, 8'h00);
      // Prescale codes 0 to 2: period and high time on both pins
      for (int c = 0; c < 3; c++)
      begin
         apb(1'b1, OFS_PERIOD, 8'h03);
         // Unit one starts at duty one, the shortest pulse
         for (int u = 0; u < 2; u++)
            cfg(u, 10'((c == 0 && u == 0) ? 1 : 1 + $urandom % 15), 1'b0);
         apb(1'b1, OFS_TIMER_CTRL, 8'(4 + c));
         for (int u = 0; u < 2; u++)
            cfg(u, 10'(duty[u]), 1'b1);
         repeat (64 * ps_q[c]) @(posedge clk);
         for (int u = 0; u < 2; u++)
         begin
            cmp(pl[u], 16 * ps_q[c]);
            cmp(hl[u], duty[u] * ps_q[c]);
         end
      end
      // New duty waits in the low register until the period ends
      r0 = rs[0];
      for (int n = 0; n < 600 && rs[0] == r0; n++)
         @(posedge clk);
      apb(1'b1, OFS_U1_DUTY_LOW, 8'h02);
      apb(1'b0, OFS_U1_DUTY_BUF, 8'h0);
      cmp(rd, 32'(duty[0] >> 2));
      repeat (300) @(posedge clk);
      apb(1'b1, OFS_U1_DUTY_BUF, 8'h5a);
      apb(1'b0, OFS_U1_DUTY_BUF, 8'h0);
      cmp(rd, 32'h2);
      // Zero duty on unit one, overlong duty on unit two
      cfg(0, 10'h0, 1'b1);
      cfg(1, 10'h3ff, 1'b1);
      repeat (800) @(posedge clk);
      r0 = rs[0] + rs[1];
      repeat (300) @(posedge clk);
      cmp(rs[0] + rs[1], r0);
      cmp({30'h0, pin}, 32'h2);
      apb(1'b1, OFS_U2_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      cmp({31'h0, pin[1]}, 32'h0);
      final_report();
   end
endmodule

// *** hdl/period_timer.sv ***
/*
 * Shared 8-bit period timer with its prescaler and quarter phase counter.
 * Assumes a synchronised active low reset and register writes from the top.
 */
`timescale 1ns/1ns
module period_timer
   import pwm_unit_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,          // Timer run bit
   input  wire logic [1:0] ps,           // Prescale field
   input  wire logic [7:0] period,       // Period register
   input  wire logic       wr_count,     // Software write of the count
   input  wire logic [7:0] wr_data,
   output logic      [7:0] count,        // Period timer value
   output logic      [1:0] fine,         // Two extra low bits of the count
   output logic            period_start  // First cycle of a new period
);

   typedef struct packed {
      logic [5:0] pre;
      logic [7:0] tmr;
      logic       start;
   } timer_s;

   timer_s s;
   timer_s next_s;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      next_s       = s;
      next_s.start = 1'b0;
      if (wr_count)
      begin
         // A count write also clears the prescaler, so the step restarts
         next_s.tmr = wr_data;
         next_s.pre = 6'h00;
      end
      else if (run)
      begin
         if (s.pre == step_last(ps))
         begin
            next_s.pre = 6'h00;
            if (s.tmr == period)
            begin
               next_s.tmr   = 8'h00;
               next_s.start = 1'b1;
            end
            else
            begin
               next_s.tmr = s.tmr + 8'h01;
            end
         end
         else
         begin
            next_s.pre = s.pre + 6'h01;
         end
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '{pre: 6'h00, tmr: TIMER_COUNT_RST, start: 1'b0};
      else
         s <= next_s;
   end

   // Low bits follow the prescaler, so one fine step is one prescale unit
   always_comb
   begin
      unique case (ps)
         2'b00:   fine = s.pre[1:0];
         2'b01:   fine = s.pre[3:2];
         default: fine = s.pre[5:4];
      endcase
   end

   assign count        = s.tmr;
   assign period_start = s.start;

   chk_wrap_to_zero : assert property (@(posedge clk) disable iff (!rst_n)
      s.start |-> s.tmr == 8'h00 && $past(s.tmr) == $past(period))
      else $error("Period start without a wrap from the period value");

   chk_step_rate : assert property (@(posedge clk) disable iff (!rst_n)
      $changed(s.tmr) && !$past(wr_count) |-> $past(s.pre) == step_last($past(ps)))
      else $error("Timer stepped before its prescaled step ended");

   chk_hold_stopped : assert property (@(posedge clk) disable iff (!rst_n)
      !run && !wr_count |=> $stable(s.tmr))
      else $error("Timer moved while stopped");

endmodule

// *** hdl/pwm_channel.sv ***
/*
 * One duty channel: duty registers, double buffer and the output latch.
 * Assumes the period timer of the top and register strobes from APB.
 */
`timescale 1ns/1ns
module pwm_channel
   import pwm_unit_pkg::*;
#(
   parameter logic [7:0] CTRL_MASK = 8'hff  // Implemented control bits
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_low,       // Duty low register write
   input  wire logic       wr_ctrl,      // Unit control register write
   input  wire logic       wr_buf,       // Duty buffer high write
   input  wire logic [7:0] wdata,
   input  wire logic       period_start,
   input  wire logic [7:0] count,
   input  wire logic [1:0] fine,
   output logic      [7:0] duty_low,
   output logic      [7:0] ctrl,
   output logic      [7:0] duty_buf,
   output logic            pin
);

   typedef struct packed {
      logic [7:0] low;   // Duty low register
      logic [7:0] ctrl;  // Unit control register
      logic [7:0] hi;    // Duty buffer high
      logic [1:0] lsb2;  // Two-bit internal latch
      logic       pin;   // PWM output latch
   } chan_s;

   chan_s s;
   chan_s next_s;
   logic  pwm;

   assign pwm = s.ctrl[UC_MODE_LSB+3 -: 2] == MODE_PWM_TOP;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      if (wr_low)
         next_s.low = wdata;
      if (wr_ctrl)
         next_s.ctrl = wdata & CTRL_MASK;
      // Buffer is only writable outside PWM mode
      if (wr_buf && !pwm)
         next_s.hi = wdata;
      if (!pwm)
         next_s.pin = 1'b0;
      else if (period_start)
      begin
         // New period: load the double buffer, raise unless duty is zero
         next_s.hi   = s.low;
         next_s.lsb2 = s.ctrl[UC_DUTY_LSB +: 2];
         next_s.pin  = {s.low, s.ctrl[UC_DUTY_LSB +: 2]} != 10'h000;
      end
      else if ({count, fine} == {s.hi, s.lsb2})
         next_s.pin = 1'b0;
      // A duty above the period never matches, so the pin stays high
      if (wr_ctrl && wdata == 8'h00)
         next_s.pin = 1'b0;
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '{low: DUTY_RST, ctrl: UNIT_CTRL_RST, hi: DUTY_RST, lsb2: 2'b00, pin: 1'b0};
      else
         s <= next_s;
   end

   assign duty_low = s.low;
   assign ctrl     = s.ctrl;
   assign duty_buf = s.hi;
   assign pin      = s.pin;

   chk_buf_frozen : assert property (@(posedge clk) disable iff (!rst_n)
      pwm && !period_start |=> $stable(s.hi))
      else $error("Duty buffer changed inside a period");

   chk_match_clear : assert property (@(posedge clk) disable iff (!rst_n)
      pwm && !period_start && {count, fine} == {s.hi, s.lsb2} |=> !s.pin)
      else $error("Pin not cleared on duty match");

endmodule

// *** hdl/pwm_unit_pkg.sv ***
/*
 * Package for the timer based PWM unit: register offsets, field positions,
 * reset values and cycle counts shared by the top and its two leaf modules.
 * Assumes a byte addressed APB with one 32-bit word per 8-bit register.
 */
package pwm_unit_pkg;

   // -------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_TIMER_COUNT  = 8'h00;
   localparam logic [7:0] OFS_PERIOD       = 8'h04;
   localparam logic [7:0] OFS_TIMER_CTRL   = 8'h08;
   localparam logic [7:0] OFS_U1_DUTY_LOW  = 8'h0c;
   localparam logic [7:0] OFS_U1_DUTY_BUF  = 8'h10;
   localparam logic [7:0] OFS_U1_CTRL      = 8'h14;
   localparam logic [7:0] OFS_U2_DUTY_LOW  = 8'h18;
   localparam logic [7:0] OFS_U2_DUTY_BUF  = 8'h1c;
   localparam logic [7:0] OFS_U2_CTRL      = 8'h20;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] TIMER_COUNT_RST  = 8'h00;
   localparam logic [7:0] PERIOD_RST       = 8'hff;
   localparam logic [7:0] TIMER_CTRL_RST   = 8'h00;
   localparam logic [7:0] UNIT_CTRL_RST    = 8'h00;
   localparam logic [7:0] DUTY_RST         = 8'h00;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int         TC_RUN_BIT       = 2;      // Timer run bit
   localparam int         TC_PS_LSB        = 0;      // Prescale field, 2 bits
   localparam int         TC_POST_LSB      = 3;      // Postscale field, 4 bits
   localparam int         UC_DUTY_LSB      = 4;      // Duty low bits, 2 bits
   localparam int         UC_MODE_LSB      = 0;      // Mode field, 4 bits
   localparam logic [1:0] MODE_PWM_TOP     = 2'b11;  // Mode 11xx selects PWM

   // -------------------------------------------------------------
   // Timing: clock period in ns, and oscillator periods per timer count at prescale one
   // -------------------------------------------------------------
   localparam int         CLK_PERIOD_NS    = 8;
   localparam int         QUARTER_CYCLES   = 4;

   // Last prescaler count of one timer step (4 x 1, 4 x 4 or 4 x 16 clocks)
   function automatic logic [5:0] step_last(input logic [1:0] ps);
      unique case (ps)
         2'b00:   step_last = 6'(QUARTER_CYCLES - 1);
         2'b01:   step_last = 6'(QUARTER_CYCLES * 4 - 1);
         default: step_last = 6'(QUARTER_CYCLES * 16 - 1);
      endcase
   endfunction

endpackage

// *** hdl/timer_based_pwm_unit.sv ***
/*
 * Top of the timer based PWM unit: APB slave, reset synchroniser, the
 * period timer and two duty channels with their output pins.
 * Assumes a single 125 MHz clock that stands for the oscillator clock and
 * an APB master that follows the usual setup and access phases.
 */
`timescale 1ns/1ns

module timer_based_pwm_unit
   import pwm_unit_pkg::*;
#(
   parameter int ADDR_W = 8  // APB address width
)
(
   input  wire logic              CLK,
   input  wire logic              RST_B,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   output logic                   UNIT1_PIN,
   output logic                   UNIT2_PIN
);

   // -------------------------------------------------------------
   // Reset synchroniser
   // -------------------------------------------------------------
   // Release is synchronised so that no flop leaves reset on a split edge
   logic [1:0] rst_sync;  // Two-stage release chain
   logic       rst_n;     // Synchronised reset used by all logic

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   assign rst_n = rst_sync[1];

   // -------------------------------------------------------------
   // Bus side state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  period;   // Period register
      logic [7:0]  tctrl;    // Timer control register
      logic [31:0] prdata;   // Read data captured in setup
      logic        pready;   // Access phase answer
      logic        pslverr;  // Unmapped address answer
      logic [10:0] gap;      // Clocks since the last period start
      logic        quiet;    // No timer write since that start
   } bus_s;

   bus_s s;       // Registered state
   bus_s next_s;  // Next value of the state

   // Decoded requests
   logic        setup;     // Setup phase seen
   logic        wr_take;   // Write takes effect this edge
   logic [7:0]  addr;      // Low address bits used for decode
   logic [7:0]  wbyte;     // Write data, low byte only
   logic        mapped;    // Address hits a register
   logic [7:0]  rbyte;     // Register read value
   logic        tm_wr;     // Write that moves the period timing

   // Strobes to the leaves
   logic        wr_count;
   logic        wr_low1;
   logic        wr_ctrl1;
   logic        wr_buf1;
   logic        wr_low2;
   logic        wr_ctrl2;
   logic        wr_buf2;

   // Timer outputs
   logic [7:0]  count;         // Period timer
   logic [1:0]  fine;          // Extension bits of the timer
   logic        period_start;  // First cycle of each period

   // Channel outputs
   logic [7:0]  low1;
   logic [7:0]  ctrl1;
   logic [7:0]  buf1;
   logic        pin1;
   logic [7:0]  low2;
   logic [7:0]  ctrl2;
   logic [7:0]  buf2;
   logic        pin2;

   assign addr  = PADDR[7:0];
   assign wbyte = PWDATA[7:0];
   assign setup = PSEL && !PENABLE;
   // Writes land on the edge where the master sees pready high
   assign wr_take = PSEL && PENABLE && PWRITE && s.pready && !s.pslverr;

   // -------------------------------------------------------------
   // Address decode and read mux
   // -------------------------------------------------------------
   // Upper address bits above the low byte must be zero to hit
   always_comb
   begin
      mapped = 1'b1;
      rbyte  = 8'h00;
      unique case (addr)
         OFS_TIMER_COUNT: rbyte = count;
         OFS_PERIOD:      rbyte = s.period;
         // Top bit of the timer control is unimplemented and reads zero
         OFS_TIMER_CTRL:  rbyte = {1'b0, s.tctrl[6:0]};
         OFS_U1_DUTY_LOW: rbyte = low1;
         OFS_U1_DUTY_BUF: rbyte = buf1;
         OFS_U1_CTRL:     rbyte = ctrl1;
         OFS_U2_DUTY_LOW: rbyte = low2;
         OFS_U2_DUTY_BUF: rbyte = buf2;
         OFS_U2_CTRL:     rbyte = ctrl2;
         default:         mapped = 1'b0;
      endcase
      if (ADDR_W > 8 && (PADDR >> 8) != '0)
         mapped = 1'b0;
      if (!mapped)
         rbyte = 8'h00;
   end

   // Write strobes, one per register held in a leaf
   assign wr_count = wr_take && addr == OFS_TIMER_COUNT;
   assign wr_low1  = wr_take && addr == OFS_U1_DUTY_LOW;
   assign wr_buf1  = wr_take && addr == OFS_U1_DUTY_BUF;
   assign wr_ctrl1 = wr_take && addr == OFS_U1_CTRL;
   assign wr_low2  = wr_take && addr == OFS_U2_DUTY_LOW;
   assign wr_buf2  = wr_take && addr == OFS_U2_DUTY_BUF;
   assign wr_ctrl2 = wr_take && addr == OFS_U2_CTRL;
   // Period, prescale and count writes restart the length bookkeeping
   assign tm_wr = wr_count || (wr_take && (addr == OFS_PERIOD || addr == OFS_TIMER_CTRL));

   // -------------------------------------------------------------
   // Next state of the bus side
   // -------------------------------------------------------------
   // Answer comes one cycle after setup; the answer is a pulse so
   // back to back transfers each get their own access phase
   always_comb
   begin
      next_s         = s;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (setup)
      begin
         next_s.pready  = 1'b1;
         next_s.pslverr = !mapped;
         // Read data is caught in setup, so a read shows the timer
         // one cycle before the access edge
         next_s.prdata  = {24'h000000, rbyte};
      end
      else if (!PSEL)
      begin
         next_s.prdata = 32'h00000000;
      end
      if (wr_take && addr == OFS_PERIOD)
         next_s.period = wbyte;
      if (wr_take && addr == OFS_TIMER_CTRL)
         next_s.tctrl = {1'b0, wbyte[6:0]};
      // Length of each period, kept only for the period check below;
      // the gap may wrap while stopped, but stopping needs a timer write
      next_s.gap   = period_start ? 11'h001 : s.gap + 11'h001;
      next_s.quiet = (period_start || s.quiet) && !tm_wr;
   end

   // -------------------------------------------------------------
   // Bus side register
   // -------------------------------------------------------------
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         s <= '{period: PERIOD_RST, tctrl: TIMER_CTRL_RST, prdata: 32'h00000000,
                pready: 1'b0, pslverr: 1'b0, gap: 11'h000, quiet: 1'b0};
      else
         s <= next_s;
   end

   assign PRDATA  = s.prdata;
   assign PREADY  = s.pready;
   assign PSLVERR = s.pslverr;

   // -------------------------------------------------------------
   // Period timer, shared by both channels
   // -------------------------------------------------------------
   period_timer u_timer (
      .clk          (CLK),
      .rst_n        (rst_n),
      .run          (s.tctrl[TC_RUN_BIT]),
      .ps           (s.tctrl[TC_PS_LSB +: 2]),
      .period       (s.period),
      .wr_count     (wr_count),
      .wr_data      (wbyte),
      .count        (count),
      .fine         (fine),
      .period_start (period_start)
   );

   // -------------------------------------------------------------
   // Duty channels
   // -------------------------------------------------------------
   // Channel one keeps all eight control bits
   pwm_channel #(.CTRL_MASK(8'hff)) u_chan1 (
      .clk          (CLK),
      .rst_n        (rst_n),
      .wr_low       (wr_low1),
      .wr_ctrl      (wr_ctrl1),
      .wr_buf       (wr_buf1),
      .wdata        (wbyte),
      .period_start (period_start),
      .count        (count),
      .fine         (fine),
      .duty_low     (low1),
      .ctrl         (ctrl1),
      .duty_buf     (buf1),
      .pin          (pin1)
   );

   // Channel two has no top control bits; they read as zero
   pwm_channel #(.CTRL_MASK(8'h3f)) u_chan2 (
      .clk          (CLK),
      .rst_n        (rst_n),
      .wr_low       (wr_low2),
      .wr_ctrl      (wr_ctrl2),
      .wr_buf       (wr_buf2),
      .wdata        (wbyte),
      .period_start (period_start),
      .count        (count),
      .fine         (fine),
      .duty_low     (low2),
      .ctrl         (ctrl2),
      .duty_buf     (buf2),
      .pin          (pin2)
   );

   // Pins come straight from the channel output latches
   assign UNIT1_PIN = pin1;
   assign UNIT2_PIN = pin2;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   logic pwm1;  // Channel one in PWM mode
   logic pwm2;  // Channel two in PWM mode
   logic [9:0] duty1;  // Programmed ten-bit duty of channel one

   assign pwm1  = ctrl1[UC_MODE_LSB+3 -: 2] == MODE_PWM_TOP;
   assign pwm2  = ctrl2[UC_MODE_LSB+3 -: 2] == MODE_PWM_TOP;
   assign duty1 = {low1, ctrl1[UC_DUTY_LSB +: 2]};

   // Every setup gets exactly one answer cycle
   chk_apb_answer : assert property (@(posedge CLK) disable iff (!rst_n)
      PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("APB answer not a one-cycle pulse after setup");

   // A zero control write drops the latch at once
   chk_zero_ctrl : assert property (@(posedge CLK) disable iff (!rst_n)
      wr_ctrl1 && wbyte == 8'h00 |=> !UNIT1_PIN)
      else $error("Output latch not low after zero control write");

   // Same forced-low rule on channel two
   chk_zero_ctrl2 : assert property (@(posedge CLK) disable iff (!rst_n)
      wr_ctrl2 && wbyte == 8'h00 |=> !UNIT2_PIN)
      else $error("Unit two latch not low after zero control write");

   // A nonzero duty raises the pin at each period start
   chk_start_high : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm1 && period_start && duty1 != 10'h000 && !wr_ctrl1 |=> UNIT1_PIN)
      else $error("Pin not raised at period start");

   // Channel two shares the timer, so it rises on the same start
   chk_start_high2 : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm2 && period_start && {low2, ctrl2[UC_DUTY_LSB +: 2]} != 10'h000 && !wr_ctrl2
      |=> UNIT2_PIN)
      else $error("Unit two pin not raised at period start");

   // Zero duty keeps the pin low for the whole period
   chk_zero_duty : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm1 && period_start && duty1 == 10'h000 |=> !UNIT1_PIN)
      else $error("Pin raised with zero duty");

   // The buffer takes the low register at each start
   chk_duty_load : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm1 && period_start |=> buf1 == $past(low1))
      else $error("Duty buffer not loaded at period start");

   // Software cannot reach the buffer in PWM mode
   chk_buffer_ro : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm1 && wr_buf1 && !period_start |=> $stable(buf1))
      else $error("Duty buffer written in PWM mode");

   // A buffer above the count cannot match, so a high pin holds
   chk_long_duty : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm2 && UNIT2_PIN && buf2 > count && !period_start && !(wr_ctrl2 && wbyte == 8'h00)
      |=> UNIT2_PIN)
      else $error("Pin cleared while the duty lies beyond the count");

   // Outside PWM mode the pin rests low; the load then sees
   // no edges at all, whatever the duty registers hold
   chk_pin_idle : assert property (@(posedge CLK) disable iff (!rst_n)
      !pwm1 |=> !UNIT1_PIN)
      else $error("Unit one pin high outside PWM mode");

   // An unmapped access returns zero data with its error
   chk_error_data : assert property (@(posedge CLK) disable iff (!rst_n)
      PSLVERR |-> PRDATA == 32'h00000000)
      else $error("Error answer carried nonzero read data");

   // Smallest duty at prescale one is one clock wide
   chk_one_clock_high : assert property (@(posedge CLK) disable iff (!rst_n)
      pwm1 && period_start && duty1 == 10'h001 && s.tctrl[1:0] == 2'b00
      && s.tctrl[TC_RUN_BIT] && !wr_take |=> UNIT1_PIN ##1 !UNIT1_PIN)
      else $error("Duty of one not one clock high at prescale one");

   // Any whole period with no timer write, measured at prescale one
   chk_period_len : assert property (@(posedge CLK) disable iff (!rst_n)
      period_start && s.quiet && s.tctrl[TC_PS_LSB +: 2] == 2'b00
      |-> s.gap == 11'((s.period + 1) * QUARTER_CYCLES))
      else $error("Period length wrong at prescale one");

endmodule
